// ---- hw/emb_defs.svh ----
`ifndef EMB_DEFS_SVH
`define EMB_DEFS_SVH

// Widths of the multiplexed port and the high address port
`define EMB_AD_W        8
`define EMB_HI_W        8
`define EMB_ADDR_W      16

// Reset values
`define EMB_STROBE_RST  1'b1
`define EMB_OE_RST      1'b0
`define EMB_PULLUP_RST  1'b1
`define EMB_BYTE_RST    8'h00

`endif

// ---- hw/emb_pkg.sv ----
`include "emb_defs.svh"

package emb_pkg;

    // Bus cycle states, Gray coded from EMB_IDLE through EMB_DATA_LO
    typedef enum logic [2:0] {
        EMB_IDLE    = 3'h0,
        EMB_ADDR_HI = 3'h1,
        EMB_ADDR_LO = 3'h3,
        EMB_DATA_HI = 3'h2,
        EMB_DATA_LO = 3'h6
    } emb_state_t;

    // One access request from the core
    typedef struct packed {
        logic                    wr;
        logic                    ext;
        logic                    blk_sel;
        logic [`EMB_ADDR_W-1:0]  addr;
        logic [`EMB_AD_W-1:0]    wdata;
    } emb_req_t;

endpackage : emb_pkg

// ---- hw/emb_ctrl.sv ----
// How it works
// - Every access: address phase then data phase
// - Address strobe low in address phase high part
// - Address out at strobe fall, high byte held till next, low byte until data phase
// - Read: port floats, data caught at strobe rise
// - Write: data driven from strobe fall, held
// - Data strobe only pulses for external access
// - Data strobe low in data phase high part
// - Strobes float on bus acknowledge or float bit
// - Strobes held high by pull-up in reset
// - Block bit picks upper or lower strobe
// - Second strobe high on internal access
// - Read/write line high read, low write
// - Read/write line set per cycle, then held
// - Second strobe, read/write driven only when enabled
// - Read/write pin weak pull-up during reset
// - Port carries low address/data, high port address
`timescale 1ns/1ps
`include "emb_defs.svh"
`default_nettype none

module emb_ctrl (
    input  wire logic                   mclk,
    input  wire logic                   rst,
    input  wire logic                   req_valid,
    input  wire emb_pkg::emb_req_t      req,
    output var  logic                   req_ready_reg,
    output var  logic                   done_reg,
    output var  logic [`EMB_AD_W-1:0]   rdata_reg,
    input  wire logic                   bus_ack,
    input  wire logic                   bus_float_bit,
    input  wire logic                   ds2_af_en,
    input  wire logic                   rw_af_en,
    output var  logic                   addr_strobe_n_reg,
    output var  logic                   addr_strobe_oe_reg,
    output var  logic                   data_strobe_n_reg,
    output var  logic                   data_strobe_oe_reg,
    output var  logic                   data_strobe2_n_reg,
    output var  logic                   data_strobe2_oe_reg,
    output var  logic                   read_write_n_reg,
    output var  logic                   read_write_oe_reg,
    output var  logic                   pullup_en_reg,
    input  wire logic [`EMB_AD_W-1:0]   addr_data_in,
    output var  logic [`EMB_AD_W-1:0]   addr_data_out_reg,
    output var  logic                   addr_data_oe_reg,
    output var  logic [`EMB_HI_W-1:0]   high_addr_reg,
    output var  logic                   high_addr_oe_reg
);

    emb_pkg::emb_state_t state_reg;
    emb_pkg::emb_state_t state_next;
    emb_pkg::emb_req_t   cur_reg;
    emb_pkg::emb_req_t   acc_next;
    logic                accept;
    logic                floating;

    assign accept   = req_valid & req_ready_reg;
    assign floating = bus_ack | bus_float_bit;
    assign acc_next = accept ? req : cur_reg;

    // Phase sequencing, two clocks per phase
    always_comb begin
        case (state_reg)
            emb_pkg::EMB_IDLE:    state_next = accept ? emb_pkg::EMB_ADDR_HI : emb_pkg::EMB_IDLE;
            emb_pkg::EMB_ADDR_HI: state_next = emb_pkg::EMB_ADDR_LO;
            emb_pkg::EMB_ADDR_LO: state_next = emb_pkg::EMB_DATA_HI;
            emb_pkg::EMB_DATA_HI: state_next = emb_pkg::EMB_DATA_LO;
            emb_pkg::EMB_DATA_LO: state_next = accept ? emb_pkg::EMB_ADDR_HI
                                                      : emb_pkg::EMB_IDLE;
            default:              state_next = emb_pkg::EMB_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= emb_pkg::EMB_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Current access latched on accept
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cur_reg <= '0;
        end else if (accept) begin
            cur_reg <= req;
        end
    end

    // Ready when the next state may take a new access
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            req_ready_reg <= 1'b0;
        end else begin
            req_ready_reg <= ~floating & (state_next == emb_pkg::EMB_IDLE ||
                                          state_next == emb_pkg::EMB_DATA_LO);
        end
    end

    // Pull-ups only while reset holds
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pullup_en_reg <= `EMB_PULLUP_RST;
        end else begin
            pullup_en_reg <= 1'b0;
        end
    end

    // Strobes and read/write level
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            addr_strobe_n_reg  <= `EMB_STROBE_RST;
            data_strobe_n_reg  <= `EMB_STROBE_RST;
            data_strobe2_n_reg <= `EMB_STROBE_RST;
            read_write_n_reg   <= `EMB_STROBE_RST;
        end else begin
            addr_strobe_n_reg  <= state_next != emb_pkg::EMB_ADDR_HI;
            data_strobe_n_reg  <= !(state_next == emb_pkg::EMB_DATA_HI && acc_next.ext
                                    && acc_next.blk_sel);
            data_strobe2_n_reg <= !(state_next == emb_pkg::EMB_DATA_HI && acc_next.ext
                                    && !acc_next.blk_sel);
            if (state_next == emb_pkg::EMB_ADDR_HI) begin
                read_write_n_reg <= !acc_next.wr;
            end
        end
    end

    // Output enables follow float, acknowledge and port setup
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            addr_strobe_oe_reg  <= `EMB_OE_RST;
            data_strobe_oe_reg  <= `EMB_OE_RST;
            data_strobe2_oe_reg <= `EMB_OE_RST;
            read_write_oe_reg   <= `EMB_OE_RST;
            high_addr_oe_reg    <= `EMB_OE_RST;
        end else begin
            addr_strobe_oe_reg  <= ~floating;
            data_strobe_oe_reg  <= ~floating;
            data_strobe2_oe_reg <= ~floating & ds2_af_en;
            read_write_oe_reg   <= ~floating & rw_af_en;
            high_addr_oe_reg    <= ~floating;
        end
    end

    // Multiplexed port: address, then write data or float
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            addr_data_out_reg <= `EMB_BYTE_RST;
            addr_data_oe_reg  <= `EMB_OE_RST;
            high_addr_reg     <= `EMB_BYTE_RST;
        end else if (state_next == emb_pkg::EMB_ADDR_HI) begin
            addr_data_out_reg <= acc_next.addr[`EMB_AD_W-1:0];
            high_addr_reg     <= acc_next.addr[`EMB_ADDR_W-1:`EMB_AD_W];
            addr_data_oe_reg  <= ~floating;
        end else if (state_next == emb_pkg::EMB_DATA_HI) begin
            addr_data_out_reg <= cur_reg.wdata;
            addr_data_oe_reg  <= cur_reg.wr & ~floating;
        end else if (floating) begin
            addr_data_oe_reg  <= 1'b0;
        end
    end

    // Read data caught as the data strobe rises
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_reg <= `EMB_BYTE_RST;
            done_reg  <= 1'b0;
        end else begin
            done_reg <= state_reg == emb_pkg::EMB_DATA_HI;
            if (state_reg == emb_pkg::EMB_DATA_HI && !cur_reg.wr) begin
                rdata_reg <= addr_data_in;
            end
        end
    end

    // Checks on the bus cycle
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    cycle_phases_a: assert property (
        state_reg == emb_pkg::EMB_ADDR_HI |=> state_reg == emb_pkg::EMB_ADDR_LO
            ##1 state_reg == emb_pkg::EMB_DATA_HI ##1 state_reg == emb_pkg::EMB_DATA_LO)
        else $error("bus cycle phases out of order");
    as_pulse_a: assert property (
        !addr_strobe_n_reg |-> state_reg == emb_pkg::EMB_ADDR_HI ##1 addr_strobe_n_reg)
        else $error("address strobe outside address phase");
    addr_hold_a: assert property (
        $rose(addr_strobe_n_reg) |-> {high_addr_reg, addr_data_out_reg}
            == cur_reg.addr ##1 high_addr_reg == $past(high_addr_reg))
        else $error("address not held");
    read_float_a: assert property (
        state_reg == emb_pkg::EMB_DATA_HI && !cur_reg.wr |-> !addr_data_oe_reg)
        else $error("port driven during read data phase");
    write_data_a: assert property (
        state_reg == emb_pkg::EMB_DATA_HI && cur_reg.wr && !$past(floating)
            |-> addr_data_oe_reg && addr_data_out_reg == cur_reg.wdata)
        else $error("write data not driven");
    internal_quiet_a: assert property (
        state_reg != emb_pkg::EMB_IDLE && !cur_reg.ext |-> data_strobe_n_reg
            && data_strobe2_n_reg)
        else $error("strobe on internal access");
    block_sel_a: assert property (
        !data_strobe_n_reg |-> cur_reg.blk_sel && data_strobe2_n_reg)
        else $error("wrong block strobe");
    float_pins_a: assert property (
        floating |=> !addr_strobe_oe_reg && !data_strobe_oe_reg
            && !data_strobe2_oe_reg && !read_write_oe_reg)
        else $error("strobes driven while floating");
    rw_level_a: assert property (
        state_reg == emb_pkg::EMB_ADDR_LO |-> (read_write_n_reg == !cur_reg.wr)
            [*4])
        else $error("read/write level wrong");
    rw_enable_a: assert property (
        !rw_af_en |=> !read_write_oe_reg)
        else $error("read/write driven without port setup");
    back_to_back_a: assert property (
        state_reg == emb_pkg::EMB_DATA_LO && accept |=> state_reg == emb_pkg::EMB_ADDR_HI)
        else $error("gap between accesses");

    read_done_c: cover property (
        state_reg == emb_pkg::EMB_DATA_HI && cur_reg.ext && !cur_reg.wr);
    write_done_c: cover property (
        state_reg == emb_pkg::EMB_DATA_HI && cur_reg.ext && cur_reg.wr);
    chained_c: cover property (state_reg == emb_pkg::EMB_DATA_LO && accept);
    float_c: cover property (bus_ack && state_reg == emb_pkg::EMB_IDLE);

endmodule : emb_ctrl

`default_nettype wire

// ---- bench/emb_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module emb_mem_model (
    input  wire logic       mclk,
    input  wire logic       as_n,
    input  wire logic       ds_n,
    input  wire logic       ds2_n,
    input  wire logic       rw_n,
    input  wire logic [7:0] hi,
    input  wire logic [7:0] bus,
    output var  logic [7:0] drv,
    output var  logic       drv_oe
);
    logic [15:0] addr_reg;
    logic [7:0]  mem [256];

    // Memory starts cleared
    initial foreach (mem[i]) mem[i] = 8'h00;

    // Address taken while strobe low, write data taken at strobe rise
    always @(posedge mclk) begin
        if (as_n === 1'b0) addr_reg <= {hi, bus};
        if ((ds_n & ds2_n) === 1'b0 && rw_n === 1'b0) mem[addr_reg[7:0]] <= bus;
    end

    // Read data presented while a strobe is low
    assign drv_oe = (ds_n & ds2_n) === 1'b0 && rw_n === 1'b1;
    assign drv    = mem[addr_reg[7:0]];
endmodule : emb_mem_model
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic mclk = 1'b0, rst = 1'b1, req_valid = 1'b0, bus_ack = 1'b0, bus_float_bit = 1'b0;
    logic ds2_af_en = 1'b1, rw_af_en = 1'b1, drv_oe, ds_seen = 1'b0, ds2_seen = 1'b0, rw_seen;
    logic req_ready_reg, done_reg, addr_strobe_n_reg, addr_strobe_oe_reg, data_strobe_n_reg;
    logic data_strobe_oe_reg, data_strobe2_n_reg, data_strobe2_oe_reg, read_write_n_reg;
    logic read_write_oe_reg, pullup_en_reg, addr_data_oe_reg, high_addr_oe_reg;
    logic [7:0]  rdata_reg, addr_data_out_reg, high_addr_reg, bus, drv, last = 8'h00;
    logic [7:0]  sh [256];
    logic [15:0] adr_seen;
    logic [27:0] note;
    logic [27:0] note_q [$];
    emb_pkg::emb_req_t req = '0;
    emb_pkg::emb_req_t r;
    int n_errors = 0, checked = 0, cycles = 0, seed = 58;

    // Port level: design, else memory, else a changing pattern
    assign bus = addr_data_oe_reg ? addr_data_out_reg : (drv_oe ? drv : ~last);

    emb_ctrl DUT (.mclk, .rst, .req_valid, .req, .req_ready_reg, .done_reg, .rdata_reg, .bus_ack,
        .bus_float_bit, .ds2_af_en, .rw_af_en, .addr_strobe_n_reg, .addr_strobe_oe_reg,
        .data_strobe_n_reg, .data_strobe_oe_reg, .data_strobe2_n_reg, .data_strobe2_oe_reg,
        .read_write_n_reg, .read_write_oe_reg, .pullup_en_reg, .addr_data_in(bus),
        .addr_data_out_reg, .addr_data_oe_reg, .high_addr_reg, .high_addr_oe_reg);

    emb_mem_model MEM (.mclk, .as_n(addr_strobe_n_reg | ~addr_strobe_oe_reg),
        .ds_n(data_strobe_n_reg | ~data_strobe_oe_reg),
        .ds2_n(data_strobe2_n_reg | ~data_strobe2_oe_reg),
        .rw_n(read_write_n_reg), .hi(high_addr_reg), .bus, .drv, .drv_oe);

    // Clock
    initial forever #10 mclk = ~mclk;

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic complete_run;
        $display("mismatches %0d, comparisons %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    // One access; request left raised for a following access
    task automatic acc(input emb_pkg::emb_req_t a);
        req = a;
        req_valid = 1'b1;
        while (req_ready_reg !== 1'b1) @(posedge mclk) #1;
        @(posedge mclk);
        note_q.push_back({~a.wr & a.ext, ~a.wr, a.ext & a.blk_sel, a.ext & ~a.blk_sel,
            a.addr, sh[a.addr[7:0]]});
        if (a.wr && a.ext) sh[a.addr[7:0]] = a.wdata;
        #1;
    endtask : acc

    // Watch pins and compare each finished access with its note
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            complete_run();
        end
        last <= bus;
        if (!rst && addr_strobe_n_reg === 1'b0) begin
            rw_seen = read_write_n_reg;
            adr_seen = {high_addr_reg, addr_data_out_reg};
        end
        if (!rst && data_strobe_n_reg === 1'b0) ds_seen = 1'b1;
        if (!rst && data_strobe2_n_reg === 1'b0) ds2_seen = 1'b1;
        if (!rst && done_reg === 1'b1) begin
            note = note_q.pop_front();
            chk("read_write_n", {15'h0, note[26]}, {15'h0, rw_seen});
            chk("strobes", {14'h0, note[25:24]}, {14'h0, ds_seen, ds2_seen});
            chk("address", note[23:8], adr_seen);
            if (note[27]) chk("rdata", {8'h0, note[7:0]}, {8'h0, rdata_reg});
            ds_seen = 1'b0;
            ds2_seen = 1'b0;
        end
    end

    // Main sequence
    initial begin
        foreach (sh[i]) sh[i] = 8'h00;
        // First edge applies reset to every register
        @(posedge mclk) #1;
        chk("reset pins", 16'h00f0, {8'h0, addr_strobe_n_reg, data_strobe_n_reg,
            data_strobe2_n_reg, pullup_en_reg, addr_strobe_oe_reg, data_strobe_oe_reg,
            data_strobe2_oe_reg, read_write_oe_reg});
        @(posedge mclk) #1 rst = 1'b0;
        for (int i = 0; i < 80; i++) begin
            r.wr = 1'($random(seed));
            r.ext = ($random(seed) % 4) != 0;
            r.blk_sel = 1'($random(seed));
            r.addr = {8'($random(seed)), 5'h00, 3'($random(seed))};
            r.wdata = 8'($random(seed));
            acc(r);
            if (i % 7 == 6) begin
                req_valid = 1'b0;
                @(posedge mclk) #1;
            end
        end
        req_valid = 1'b0;
        // Floating by acknowledge, by mode bit, then pins not set to alternate use
        for (int k = 0; k < 3; k++) begin
            repeat (6) @(posedge mclk);
            #1;
            bus_ack = (k == 0);
            bus_float_bit = (k == 1);
            {ds2_af_en, rw_af_en} = (k == 2) ? 2'b00 : 2'b11;
            repeat (2) @(posedge mclk);
            #1;
            chk("pin drive", (k == 2) ? 16'h66 : 16'h0, {9'h0, addr_strobe_oe_reg,
                data_strobe_oe_reg, data_strobe2_oe_reg, read_write_oe_reg,
                high_addr_oe_reg, req_ready_reg, pullup_en_reg});
        end
        repeat (4) @(posedge mclk);
        // Reset again in mid-run, asynchronously
        #1 rst = 1'b1;
        #1;
        chk("reset again", 16'h00f0, {8'h0, addr_strobe_n_reg, data_strobe_n_reg,
            data_strobe2_n_reg, pullup_en_reg, addr_strobe_oe_reg, data_strobe_oe_reg,
            data_strobe2_oe_reg, read_write_oe_reg});
        @(posedge mclk) #1 rst = 1'b0;
        repeat (2) @(posedge mclk);
        chk("pending notes", 16'h0, 16'(note_q.size()));
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
